/* design/rpc_pkg.sv */
package rpc_pkg;

    localparam int NUM_CHAN = 24;

    localparam logic [7:0] ADDR_LO_BASE = 8'h01;
    localparam logic [7:0] ADDR_DTRK_BASE = 8'h21;
    localparam logic [7:0] ADDR_STRK_BASE = 8'h41;

    localparam int SUBST_LSB = 5;
    localparam int MSB_INV_BIT = 4;
    localparam int ODD_INV_BIT = 3;
    localparam int EVEN_INV_BIT = 2;
    localparam int LSB_GAP_BIT = 1;
    localparam int CHAN_GAP_BIT = 0;
    localparam int TEST_BIT = 6;
    localparam int SIG_TRUNK_BIT = 4;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic EXT_EN_RESET = 1'b1;
    localparam logic [7:0] STRK_RD_MASK = 8'h5F;

    localparam logic [2:0] SUB_NONE = 3'h0;
    localparam logic [2:0] SUB_DTRK = 3'h1;
    localparam logic [2:0] SUB_ALAW = 3'h2;
    localparam logic [2:0] SUB_ULAW = 3'h3;

    localparam logic [7:0] INV_MSB_MASK = 8'h80;
    localparam logic [7:0] INV_ODD_MASK = 8'h2A;
    localparam logic [7:0] INV_EVEN_MASK = 8'h55;
    localparam logic [7:0] GAP_NONE = 8'h00;
    localparam logic [7:0] GAP_LSB_MASK = 8'h01;
    localparam logic [7:0] GAP_ALL_MASK = 8'hFF;
    localparam logic [7:0] TEST_MASK_W8 = 8'hFF;
    localparam logic [7:0] TEST_MASK_W7 = 8'hFE;

    localparam logic [1:0] PRBS_MODE_W8 = 2'h1;
    localparam logic [1:0] PRBS_MODE_W7 = 2'h2;

    // Milliwatt sequences, frame phase 0 in the low byte
    localparam logic [63:0] ALAW_MW = 64'hB4A1A1B4_34212134;
    localparam logic [63:0] ULAW_MW = 64'h9E8B8B9E_1E0B0B1E;

    typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_DM, FMT_SLC96} rpc_fmt_e;

    typedef struct packed {
        logic valid;
        logic [4:0] chan;
        logic [7:0] octet;
        logic sig_valid;
        logic [3:0] sig;
    } rpc_line_s;

    typedef struct packed {
        logic valid;
        logic [4:0] chan;
        logic [7:0] octet;
        logic sig_valid;
        logic [3:0] sig;
        logic [7:0] gap;
    } rpc_bp_s;

endpackage

/* design/rpc_top.sv */
// What this block does
// - Signaling buffer 01H-18H, one per channel
// - Extract enable captures ABCD while frame synced, except in DM format
// - Captured ABCD read-only in bits 3..0
// - SF format: C,D repeat A,B
// - Control 01H, data trunk 21H, signaling 41H
// - Per-channel selector only when global is 000
// - Selector: none, trunk, A-law, mu-law milliwatt
// - Three inversion controls: MSB, odd, even bits
// - Gapping only in master mode with enable
// - LSB gap bit 8; channel gap whole
// - Eight-bit data trunk code per channel
// - Test bit routes to detector or generator
// - Test only in 8-bit or 7-bit mode
// - Selected channels form one continuous stream
// - Signaling trunk enable substitutes trunk code
// - Global or per-channel enable selects trunk code
// - Read: address with read, data appears
`timescale 1ns/1ps
`default_nettype none
module rpc_top #(
    parameter int NUM_CHAN = rpc_pkg::NUM_CHAN
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire rpc_pkg::rpc_line_s line_in,
    input wire logic [7:0] prbs_gen_octet_in,
    input wire rpc_pkg::rpc_fmt_e fmt_in,
    input wire logic frame_sync_in,
    input wire logic [2:0] global_substitution_sel_in,
    input wire logic global_sig_trunk_en_in,
    input wire logic rx_clock_master_in,
    input wire logic per_chan_ctrl_en_in,
    input wire logic [1:0] prbs_width_mode_in,
    input wire logic prbs_direction_in,
    input wire logic ind_data_wr_in,
    input wire logic [7:0] ind_data_in,
    input wire logic acc_wr_in,
    input wire logic acc_bank_in,
    input wire logic [7:0] acc_addr_in,
    input wire logic read_not_write_in,
    output var logic [7:0] ind_data_out,
    output var rpc_pkg::rpc_bp_s bp_out,
    output var logic prbs_det_valid_out,
    output var logic [7:0] prbs_det_octet_out,
    output var logic prbs_det_seven_out,
    output var logic prbs_gen_take_out
);

    localparam logic [7:0] SPAN = 8'(NUM_CHAN);
    localparam logic [4:0] LAST_CHAN = 5'(NUM_CHAN - 1);

    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    logic [7:0] ctrl_r [NUM_CHAN];
    logic [7:0] dtrk_r [NUM_CHAN];
    logic [7:0] strk_r [NUM_CHAN];
    logic ext_en_r [NUM_CHAN];
    logic [3:0] ext_sig_r [NUM_CHAN];
    logic [2:0] mw_phase_r;

    // Indirect access decode
    wire logic [7:0] off_lo = acc_addr_in - rpc_pkg::ADDR_LO_BASE;
    wire logic [7:0] off_dtrk = acc_addr_in - rpc_pkg::ADDR_DTRK_BASE;
    wire logic [7:0] off_strk = acc_addr_in - rpc_pkg::ADDR_STRK_BASE;
    wire logic hit_lo = off_lo < SPAN;
    wire logic hit_dtrk = off_dtrk < SPAN;
    wire logic hit_strk = off_strk < SPAN;
    wire logic [4:0] idx_lo = off_lo[4:0];
    wire logic [4:0] idx_dtrk = off_dtrk[4:0];
    wire logic [4:0] idx_strk = off_strk[4:0];
    wire logic wr_w = acc_wr_in && !read_not_write_in;
    wire logic rd_w = acc_wr_in && read_not_write_in;

    wire logic [7:0] rd_ext_w = hit_lo ?
        {3'h0, ext_en_r[idx_lo], ext_sig_r[idx_lo]} : 8'h00;
    wire logic [7:0] rd_plc_w = hit_lo ? ctrl_r[idx_lo] :
        hit_dtrk ? dtrk_r[idx_dtrk] :
        hit_strk ? (strk_r[idx_strk] & rpc_pkg::STRK_RD_MASK) : 8'h00;
    wire logic [7:0] rd_data_w = acc_bank_in ? rd_plc_w : rd_ext_w;

    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ind_data_out <= rpc_pkg::REG_RESET;
        end else if (rd_w) begin
            ind_data_out <= rd_data_w;
        end else if (ind_data_wr_in) begin
            ind_data_out <= ind_data_in;
        end
    end

    // Extraction only in framed formats that carry signaling
    wire logic sync_ok = frame_sync_in && (fmt_in != rpc_pkg::FMT_DM);
    wire logic is_sf = fmt_in == rpc_pkg::FMT_SF;
    wire logic [3:0] sig_cap_w = is_sf ? {line_in.sig[3:2], line_in.sig[3:2]} :
        line_in.sig;

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        localparam logic [4:0] CI = 5'(c);
        wire logic ext_we = wr_w && !acc_bank_in && hit_lo && idx_lo == CI;
        wire logic ctrl_we = wr_w && acc_bank_in && hit_lo && idx_lo == CI;
        wire logic dtrk_we = wr_w && acc_bank_in && hit_dtrk && idx_dtrk == CI;
        wire logic strk_we = wr_w && acc_bank_in && hit_strk && idx_strk == CI;
        wire logic cap = line_in.valid && line_in.sig_valid && line_in.chan == CI &&
            ext_en_r[c] && sync_ok;

        always_ff @(posedge clock_in or negedge rst_n_r) begin
            if (!rst_n_r) begin
                ctrl_r[c] <= rpc_pkg::REG_RESET;
                dtrk_r[c] <= rpc_pkg::REG_RESET;
                strk_r[c] <= rpc_pkg::REG_RESET;
                ext_en_r[c] <= rpc_pkg::EXT_EN_RESET;
                ext_sig_r[c] <= 4'h0;
            end else begin
                if (ctrl_we) begin
                    ctrl_r[c] <= ind_data_out;
                end
                if (dtrk_we) begin
                    dtrk_r[c] <= ind_data_out;
                end
                if (strk_we) begin
                    strk_r[c] <= ind_data_out & rpc_pkg::STRK_RD_MASK;
                end
                if (ext_we) begin
                    ext_en_r[c] <= ind_data_out[rpc_pkg::SIG_TRUNK_BIT];
                end
                if (cap) begin
                    ext_sig_r[c] <= sig_cap_w;
                end
            end
        end

        ext_sf_a: assert property (@(posedge clock_in) disable iff (!rst_n_r)
            (cap && is_sf) |=> ext_sig_r[c][1:0] == ext_sig_r[c][3:2])
            else $error("SF extraction does not repeat A and B");
        ext_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_r)
            (!ext_en_r[c] || !sync_ok) |=> $stable(ext_sig_r[c]))
            else $error("Signaling captured while disabled");
    end

    // Payload path
    wire logic [4:0] ch = line_in.chan;
    wire logic ch_ok = line_in.valid && ch < 5'(NUM_CHAN);
    wire logic [7:0] cc = ctrl_r[ch];
    wire logic [7:0] sc = strk_r[ch];
    wire logic [7:0] dt = dtrk_r[ch];

    wire logic [2:0] eff_sel = (global_substitution_sel_in != rpc_pkg::SUB_NONE) ?
        global_substitution_sel_in : cc[rpc_pkg::SUBST_LSB +: 3];
    wire logic [5:0] mw_idx = {mw_phase_r, 3'h0};
    wire logic [7:0] alaw_w = rpc_pkg::ALAW_MW[mw_idx +: 8];
    wire logic [7:0] ulaw_w = rpc_pkg::ULAW_MW[mw_idx +: 8];
    wire logic [7:0] sub_octet = (eff_sel == rpc_pkg::SUB_DTRK) ? dt :
        (eff_sel == rpc_pkg::SUB_ALAW) ? alaw_w :
        (eff_sel == rpc_pkg::SUB_ULAW) ? ulaw_w :
        line_in.octet;

    wire logic [7:0] inv_mask =
        (cc[rpc_pkg::MSB_INV_BIT] ? rpc_pkg::INV_MSB_MASK : 8'h00) |
        (cc[rpc_pkg::ODD_INV_BIT] ? rpc_pkg::INV_ODD_MASK : 8'h00) |
        (cc[rpc_pkg::EVEN_INV_BIT] ? rpc_pkg::INV_EVEN_MASK : 8'h00);
    wire logic [7:0] cond_octet = sub_octet ^ inv_mask;

    wire logic mode_w7 = prbs_width_mode_in == rpc_pkg::PRBS_MODE_W7;
    wire logic test_on = sc[rpc_pkg::TEST_BIT] &&
        (mode_w7 || prbs_width_mode_in == rpc_pkg::PRBS_MODE_W8);
    wire logic [7:0] test_mask = mode_w7 ? rpc_pkg::TEST_MASK_W7 : rpc_pkg::TEST_MASK_W8;
    wire logic gen_on = test_on && prbs_direction_in;
    wire logic det_on = test_on && !prbs_direction_in;
    wire logic [7:0] out_octet = gen_on ?
        ((cond_octet & ~test_mask) | (prbs_gen_octet_in & test_mask)) : cond_octet;

    wire logic sig_trunk = global_sig_trunk_en_in || sc[rpc_pkg::SIG_TRUNK_BIT];
    wire logic [3:0] out_sig = sig_trunk ? sc[3:0] : line_in.sig;

    wire logic gap_ok = rx_clock_master_in && per_chan_ctrl_en_in;
    wire logic [7:0] gap_w = !gap_ok ? rpc_pkg::GAP_NONE :
        cc[rpc_pkg::CHAN_GAP_BIT] ? rpc_pkg::GAP_ALL_MASK :
        cc[rpc_pkg::LSB_GAP_BIT] ? rpc_pkg::GAP_LSB_MASK : rpc_pkg::GAP_NONE;

    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mw_phase_r <= 3'h0;
        end else if (line_in.valid && ch == LAST_CHAN) begin
            mw_phase_r <= mw_phase_r + 3'h1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bp_out <= '0;
        end else begin
            bp_out <= {ch_ok, ch, out_octet, line_in.sig_valid && ch_ok, out_sig, gap_w};
        end
    end

    // Selected channels feed the pattern logic back to back
    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prbs_det_valid_out <= 1'b0;
            prbs_det_octet_out <= 8'h00;
            prbs_det_seven_out <= 1'b0;
            prbs_gen_take_out <= 1'b0;
        end else begin
            prbs_det_valid_out <= ch_ok && det_on;
            prbs_det_octet_out <= line_in.octet;
            prbs_det_seven_out <= mode_w7;
            prbs_gen_take_out <= ch_ok && gen_on;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_r);

    wire logic plain_w = ch_ok && !gen_on && inv_mask == 8'h00;

    sub_global_a: assert property (
        (plain_w && global_substitution_sel_in == rpc_pkg::SUB_DTRK) |=>
        bp_out.octet == $past(dt))
        else $error("Global trunk substitution not applied");
    mw_alaw_a: assert property (
        (plain_w && eff_sel == rpc_pkg::SUB_ALAW) |=>
        bp_out.octet inside {8'h34, 8'h21, 8'hB4, 8'hA1})
        else $error("A-law milliwatt byte wrong");
    reserved_sel_a: assert property (
        (plain_w && eff_sel > rpc_pkg::SUB_ULAW) |=> bp_out.octet == $past(line_in.octet))
        else $error("Reserved selector altered data");
    invert_all_a: assert property (
        (ch_ok && !gen_on && eff_sel == rpc_pkg::SUB_NONE && cc[4:2] == 3'h7) |=>
        bp_out.octet == ~$past(line_in.octet))
        else $error("Full inversion wrong");
    gap_mode_a: assert property (
        (ch_ok && gap_ok && cc[rpc_pkg::CHAN_GAP_BIT]) |=>
        bp_out.gap == rpc_pkg::GAP_ALL_MASK)
        else $error("Channel gap not applied");
    gap_off_a: assert property (
        !gap_ok |=> bp_out.gap == rpc_pkg::GAP_NONE)
        else $error("Gap outside master mode");
    sig_trunk_a: assert property (
        (ch_ok && global_sig_trunk_en_in) |=> bp_out.sig == $past(sc[3:0]))
        else $error("Signaling trunk code not inserted");
    gen_seven_a: assert property (
        (ch_ok && gen_on && mode_w7) |=>
        prbs_gen_take_out && bp_out.octet[0] == $past(cond_octet[0]))
        else $error("7-bit test replaced the LSB");
    test_idle_a: assert property (
        (ch_ok && !test_on) |=> !prbs_det_valid_out && !prbs_gen_take_out)
        else $error("Pattern path used for an unselected channel");

    // Substitution, gapping, line signaling and channel range per channel
    gap_lsb_a: assert property (
        (ch_ok && gap_ok && !cc[rpc_pkg::CHAN_GAP_BIT] && cc[rpc_pkg::LSB_GAP_BIT]) |=>
        bp_out.gap == rpc_pkg::GAP_LSB_MASK)
        else $error("LSB gap not applied");

    mw_ulaw_a: assert property (
        (plain_w && eff_sel == rpc_pkg::SUB_ULAW) |=>
        bp_out.octet inside {8'h1E, 8'h0B, 8'h9E, 8'h8B})
        else $error("mu-law milliwatt byte wrong");

    dtrk_chan_a: assert property (
        (plain_w && eff_sel == rpc_pkg::SUB_DTRK) |=> bp_out.octet == $past(dt))
        else $error("Channel trunk code not applied");

    sub_none_a: assert property (
        (plain_w && eff_sel == rpc_pkg::SUB_NONE) |=> bp_out.octet == $past(line_in.octet))
        else $error("Unselected channel data altered");

    mw_step_a: assert property (
        (line_in.valid && ch == LAST_CHAN) |=> mw_phase_r == $past(mw_phase_r) + 3'h1)
        else $error("Milliwatt phase did not advance");

    sig_line_a: assert property (
        (ch_ok && !sig_trunk) |=> bp_out.sig == $past(line_in.sig))
        else $error("Line signaling not passed");

    bad_chan_a: assert property (
        (line_in.valid && !ch_ok) |=> !bp_out.valid)
        else $error("Channel out of range forwarded");

    // Pattern test routing
    det_route_a: assert property (
        (ch_ok && det_on) |=> prbs_det_valid_out && prbs_det_octet_out == $past(line_in.octet))
        else $error("Detector did not receive channel octet");

    gen_eight_a: assert property (
        (ch_ok && gen_on && !mode_w7) |=> bp_out.octet == $past(prbs_gen_octet_in))
        else $error("8-bit test did not replace the octet");

    // Indirect register reads and loads
    ext_rd_a: assert property (
        (rd_w && !acc_bank_in) |=> ind_data_out[7:5] == 3'h0)
        else $error("Signaling buffer reserved bits set");

    strk_rd_a: assert property (
        (rd_w && acc_bank_in && hit_strk) |=> (ind_data_out & ~rpc_pkg::STRK_RD_MASK) == 8'h00)
        else $error("Signaling trunk reserved bits set");

    unmapped_rd_a: assert property (
        (rd_w && !hit_lo && !hit_dtrk && !hit_strk) |=> ind_data_out == 8'h00)
        else $error("Unmapped read returned data");

    data_load_a: assert property (
        (ind_data_wr_in && !rd_w) |=> ind_data_out == $past(ind_data_in))
        else $error("Indirect data register not loaded");

    sequence ctrl0_wr_s;
        wr_w && acc_bank_in && acc_addr_in == rpc_pkg::ADDR_LO_BASE;
    endsequence
    sequence ctrl0_rd_s;
        rd_w && acc_bank_in && acc_addr_in == rpc_pkg::ADDR_LO_BASE;
    endsequence
    wr_read_back_a: assert property (
        ctrl0_wr_s ##1 ctrl0_rd_s |=> ind_data_out == $past(ind_data_out, 2))
        else $error("Indirect read does not return written byte");

endmodule
`default_nettype wire

/* sim/rpc_bp_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module rpc_bp_sink (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire rpc_pkg::rpc_bp_s bp_in,
    output var logic stb_out,
    output var rpc_pkg::rpc_bp_s word_out
);
    // Backplane latch: one received octet per valid cycle
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stb_out <= 1'b0;
            word_out <= '0;
        end else begin
            stb_out <= bp_in.valid;
            if (bp_in.valid) begin
                word_out <= bp_in;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/rx_channel_payload_conditioning_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_channel_payload_conditioning_bench;
    logic clk, nrst, sync, gst, mst, per_chan_ctrl_en, dir, dwr, awr, bank, rnw, det_v, det7, take, got_v;
    rpc_pkg::rpc_line_s ln;
    rpc_pkg::rpc_fmt_e fmt;
    rpc_pkg::rpc_bp_s bp, got;
    logic [7:0] gen, din, addr, dout, det_oct, det_exp, ctrl, dt, st, o, e8, gp;
    logic [3:0] s;
    logic [2:0] gsel, sub;
    logic [1:0] pm;
    logic [19:0] q[$];
    int fail_count, n_checks, n_det, n_take, c;

    rpc_top dut (.clock_in(clk), .nrst_in(nrst), .line_in(ln), .prbs_gen_octet_in(gen),
        .fmt_in(fmt), .frame_sync_in(sync), .global_substitution_sel_in(gsel),
        .global_sig_trunk_en_in(gst), .rx_clock_master_in(mst), .per_chan_ctrl_en_in(per_chan_ctrl_en),
        .prbs_width_mode_in(pm), .prbs_direction_in(dir), .ind_data_wr_in(dwr),
        .ind_data_in(din), .acc_wr_in(awr), .acc_bank_in(bank), .acc_addr_in(addr),
        .read_not_write_in(rnw), .ind_data_out(dout), .bp_out(bp),
        .prbs_det_valid_out(det_v), .prbs_det_octet_out(det_oct),
        .prbs_det_seven_out(det7), .prbs_gen_take_out(take));
    rpc_bp_sink sink (.clock_in(clk), .nrst_in(nrst), .bp_in(bp), .stb_out(got_v),
        .word_out(got));

    task automatic chk(input logic [19:0] a, input logic [19:0] e, input string m);
        n_checks++;
        if (a !== e) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, a, e);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #2;
    endtask
    // Data register first, then the access with write select
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        step;
        dwr = 1'b1;
        din = d;
        step;
        dwr = 1'b0;
        awr = 1'b1;
        bank = b;
        addr = a;
        rnw = 1'b0;
        step;
        awr = 1'b0;
    endtask
    task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] e);
        step;
        awr = 1'b1;
        bank = b;
        addr = a;
        rnw = 1'b1;
        step;
        awr = 1'b0;
        chk({12'h000, dout}, {12'h000, e}, "register read");
    endtask
    task automatic send(input int ch, input logic [7:0] oc, input logic [3:0] sg,
        input logic [19:0] e);
        step;
        ln = '{1'b1, 5'(ch), oc, 1'b1, sg};
        q.push_back(e);
        step;
        ln.valid = 1'b0;
    endtask
    task automatic end_sim;
        chk(20'(q.size()), 20'h00000, "pending octets");
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        if (got_v) begin
            chk({got.octet, got.sig, got.gap}, q.size() ? q.pop_front() : 20'hFFFFF, "octet");
        end
        if (det_v) begin
            n_det++;
            chk({12'h000, det_oct}, {12'h000, det_exp}, "detector octet");
            chk({19'h00000, det7}, 20'h00000, "detector width");
        end
        if (take) begin
            n_take++;
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end

    initial begin
        {nrst, sync, gst, mst, per_chan_ctrl_en, dir, dwr, awr, bank, rnw} = '0;
        ln = '0;
        fmt = rpc_pkg::FMT_ESF;
        {gen, din, addr, det_exp, gsel, pm} = '0;
        void'($urandom(32'h46E46E3D));
        repeat (4) @(posedge clk);
        #2 nrst = 1'b1;
        repeat (3) step;
        rd(1'b0, 8'h01, 8'h10);
        rd(1'b1, 8'h01, 8'h00);
        wr(1'b1, 8'h19, 8'hA5);
        rd(1'b1, 8'h19, 8'h00);
        step;
        dwr = 1'b1;
        din = 8'h5A;
        step;
        dwr = 1'b0;
        awr = 1'b1;
        bank = 1'b1;
        addr = 8'h01;
        rnw = 1'b0;
        step;
        rnw = 1'b1;
        step;
        awr = 1'b0;
        chk({12'h000, dout}, 20'h0005A, "read after write");
        $display("test reset_map done");
        for (int i = 0; i < 40; i++) begin
            c = i % 23;
            {ctrl, dt, st, o} = $urandom;
            s = 4'($urandom);
            gsel = ($urandom % 2) ? 3'($urandom) : 3'h0;
            {gst, mst, per_chan_ctrl_en} = 3'($urandom);
            wr(1'b1, 8'h01 + 8'(c), ctrl);
            wr(1'b1, 8'h21 + 8'(c), dt);
            wr(1'b1, 8'h41 + 8'(c), st);
            sub = (gsel != 3'h0) ? gsel : ctrl[7:5];
            e8 = sub == 3'h1 ? dt : sub == 3'h2 ? rpc_pkg::ALAW_MW[7:0] :
                sub == 3'h3 ? rpc_pkg::ULAW_MW[7:0] : o;
            e8 ^= (ctrl[4] ? 8'h80 : 8'h00) | (ctrl[3] ? 8'h2A : 8'h00) |
                (ctrl[2] ? 8'h55 : 8'h00);
            gp = !(mst && per_chan_ctrl_en) ? 8'h00 : ctrl[0] ? 8'hFF : ctrl[1] ? 8'h01 : 8'h00;
            send(c, o, s, {e8, (gst || st[4]) ? st[3:0] : s, gp});
            rd(1'b1, 8'h21 + 8'(c), dt);
            rd(1'b1, 8'h41 + 8'(c), st & rpc_pkg::STRK_RD_MASK);
        end
        $display("test random_conditioning done");
        {gsel, gst, mst} = '0;
        wr(1'b1, 8'h18, 8'h40);
        wr(1'b1, 8'h01, 8'h40);
        wr(1'b1, 8'h58, 8'h00);
        wr(1'b1, 8'h41, 8'h00);
        send(23, 8'h00, 4'h0, {rpc_pkg::ALAW_MW[7:0], 4'h0, 8'h00});
        send(0, 8'h00, 4'h0, {rpc_pkg::ALAW_MW[15:8], 4'h0, 8'h00});
        $display("test milliwatt_phase done");
        wr(1'b1, 8'h03, 8'h00);
        wr(1'b1, 8'h43, 8'h00);
        sync = 1'b1;
        send(2, 8'h3C, 4'hA, {8'h3C, 4'hA, 8'h00});
        rd(1'b0, 8'h03, 8'h1A);
        fmt = rpc_pkg::FMT_SF;
        send(2, 8'h3C, 4'h4, {8'h3C, 4'h4, 8'h00});
        rd(1'b0, 8'h03, 8'h15);
        sync = 1'b0;
        send(2, 8'h3C, 4'hF, {8'h3C, 4'hF, 8'h00});
        rd(1'b0, 8'h03, 8'h15);
        sync = 1'b1;
        fmt = rpc_pkg::FMT_DM;
        wr(1'b0, 8'h03, 8'hEF);
        send(2, 8'h3C, 4'hF, {8'h3C, 4'hF, 8'h00});
        rd(1'b0, 8'h03, 8'h05);
        fmt = rpc_pkg::FMT_ESF;
        send(2, 8'h3C, 4'hF, {8'h3C, 4'hF, 8'h00});
        rd(1'b0, 8'h03, 8'h05);
        $display("test signaling_capture done");
        wr(1'b1, 8'h05, 8'h00);
        wr(1'b1, 8'h45, 8'h40);
        o = $urandom;
        send(4, o, 4'h0, {o, 4'h0, 8'h00});
        pm = rpc_pkg::PRBS_MODE_W8;
        det_exp = o;
        send(4, o, 4'h0, {o, 4'h0, 8'h00});
        gen = $urandom;
        pm = rpc_pkg::PRBS_MODE_W7;
        dir = 1'b1;
        send(4, o, 4'h0, {gen[7:1], o[0], 4'h0, 8'h00});
        repeat (2) step;
        chk(20'(n_det), 20'h00001, "detector count");
        chk(20'(n_take), 20'h00001, "generator takes");
        $display("test pattern_test done");
        end_sim();
    end
endmodule
`default_nettype wire
